// ---- hdl/lfcb_pkg.sv ----
// package: register map, reset values and widths for the left filter coefficient bank
package lfcb_pkg;
  localparam int LFCB_NUM_REGS = 10;
  localparam int LFCB_NUM_COEFS = 5;
  // register indices (page-local register numbers); byte address is four times the index
  localparam logic [7:0] LFCB_IDX_DENOM_FOUR_HIGH = 8'h11;
  localparam logic [7:0] LFCB_IDX_DENOM_FOUR_LOW = 8'h12;
  localparam logic [7:0] LFCB_IDX_DENOM_FIVE_HIGH = 8'h13;
  localparam logic [7:0] LFCB_IDX_DENOM_FIVE_LOW = 8'h14;
  localparam logic [7:0] LFCB_IDX_NUMER_ZERO_HIGH = 8'h15;
  localparam logic [7:0] LFCB_IDX_NUMER_ZERO_LOW = 8'h16;
  localparam logic [7:0] LFCB_IDX_NUMER_ONE_HIGH = 8'h17;
  localparam logic [7:0] LFCB_IDX_NUMER_ONE_LOW = 8'h18;
  localparam logic [7:0] LFCB_IDX_DENOM_ONE_HIGH = 8'h19;
  localparam logic [7:0] LFCB_IDX_DENOM_ONE_LOW = 8'h1A;
  localparam logic [7:0] LFCB_IDX_FIRST = LFCB_IDX_DENOM_FOUR_HIGH;
  // reset values, in register order
  localparam logic [7:0] LFCB_RST_DENOM_FOUR_HIGH = 8'h7D;
  localparam logic [7:0] LFCB_RST_DENOM_FOUR_LOW = 8'h83;
  localparam logic [7:0] LFCB_RST_DENOM_FIVE_HIGH = 8'h84;
  localparam logic [7:0] LFCB_RST_DENOM_FIVE_LOW = 8'hEE;
  localparam logic [7:0] LFCB_RST_NUMER_ZERO_HIGH = 8'h39;
  localparam logic [7:0] LFCB_RST_NUMER_ZERO_LOW = 8'h55;
  localparam logic [7:0] LFCB_RST_NUMER_ONE_HIGH = 8'hF3;
  localparam logic [7:0] LFCB_RST_NUMER_ONE_LOW = 8'h2D;
  localparam logic [7:0] LFCB_RST_DENOM_ONE_HIGH = 8'h53;
  localparam logic [7:0] LFCB_RST_DENOM_ONE_LOW = 8'h7E;
  localparam logic [1:0] LFCB_RESP_OKAY = 2'h0;
  localparam logic [1:0] LFCB_RESP_SLVERR = 2'h2;
endpackage : lfcb_pkg

// ---- hdl/lfcb_coef_reg.sv ----
// one coefficient: high and low byte registers forming a signed 16-bit value
`timescale 1ns/100ps
module lfcb_coef_reg #(
  parameter logic [7:0] RST_HIGH = 8'h00, // reset of high byte
  parameter logic [7:0] RST_LOW = 8'h00 // reset of low byte
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic wr_high, // write strobe high byte
  input wire logic wr_low, // write strobe low byte
  input wire logic [7:0] wdata, // write byte
  output logic [7:0] high_q, // high byte
  output logic [7:0] low_q, // low byte
  output logic signed [15:0] coef // two's complement coefficient
);
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } lfcb_coef_state_t;
  lfcb_coef_state_t s_q;
  lfcb_coef_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (wr_high) begin
      s_d.high = wdata;
    end
    if (wr_low) begin
      s_d.low = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '{high: RST_HIGH, low: RST_LOW};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign high_q = s_q.high;
  assign low_q = s_q.low;
  assign coef = $signed({s_q.high, s_q.low});
endmodule : lfcb_coef_reg

// ---- hdl/lfcb_bank.sv ----
// left-channel effects and de-emphasis coefficient bank behind an AXI4-Lite slave
// How it works
// - coefficient is signed 16 bits from two bytes
// - any value -32768 to +32767 accepted
// - effects denominator four resets to 0x7D83
// - effects denominator five resets to 0x84EE
// - de-emphasis numerator zero resets to 0x3955
// - de-emphasis numerator one resets to 0xF32D
// - de-emphasis denominator high byte resets 0x53
// - de-emphasis denominator low byte resets 0x7E
// - each register eight bits, read and write
`timescale 1ns/100ps
module lfcb_bank #(
  parameter int ADDR_W = 8 // byte address width
) (
  input wire logic CLK_SYS, // 100 MHz clock
  input wire logic RST_N, // sync reset, active low
  input wire logic CE, // clock enable, freezes all state when low; sync reset still clears it
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // write strobes
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output logic [31:0] S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY, // read data ready
  output logic signed [15:0] EFFECTS_DENOM_FOUR, // coefficient to filter
  output logic signed [15:0] EFFECTS_DENOM_FIVE, // coefficient to filter
  output logic signed [15:0] DEEMPH_NUMER_ZERO, // coefficient to filter
  output logic signed [15:0] DEEMPH_NUMER_ONE, // coefficient to filter
  output logic signed [15:0] DEEMPH_DENOM_ONE // coefficient to filter
);
  import lfcb_pkg::*;

  // refuse address widths the decoder cannot serve
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must be 8..32");
  end

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [7:0] wbyte;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } lfcb_bus_t;

  lfcb_bus_t s_q;
  lfcb_bus_t s_d;

  localparam logic [7:0] RST_TAB [LFCB_NUM_REGS] = '{
    LFCB_RST_DENOM_FOUR_HIGH, LFCB_RST_DENOM_FOUR_LOW,
    LFCB_RST_DENOM_FIVE_HIGH, LFCB_RST_DENOM_FIVE_LOW,
    LFCB_RST_NUMER_ZERO_HIGH, LFCB_RST_NUMER_ZERO_LOW,
    LFCB_RST_NUMER_ONE_HIGH, LFCB_RST_NUMER_ONE_LOW,
    LFCB_RST_DENOM_ONE_HIGH, LFCB_RST_DENOM_ONE_LOW};

  logic [7:0] reg_val [LFCB_NUM_REGS];
  logic [LFCB_NUM_REGS-1:0] wr_sel;
  logic signed [15:0] coef [LFCB_NUM_COEFS];
  logic do_write;
  logic [ADDR_W-1:0] w_addr;
  logic w_hit;
  logic [3:0] w_slot;
  logic r_hit;
  logic [3:0] r_slot;

  // map byte address to slot; word aligned and in range only
  function automatic logic [4:0] lfcb_decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    logic [ADDR_W-3:0] rel;
    idx = a[ADDR_W-1:2];
    rel = idx - (ADDR_W-2)'(LFCB_IDX_FIRST);
    if (a[1:0] == 2'b00 && idx >= (ADDR_W-2)'(LFCB_IDX_FIRST) && rel < (ADDR_W-2)'(LFCB_NUM_REGS)) begin
      lfcb_decode = {1'b1, rel[3:0]};
    end else begin
      lfcb_decode = 5'h00;
    end
  endfunction : lfcb_decode

  assign w_addr = s_q.aw_held ? s_q.awaddr : S_AXI_AWADDR;
  assign {w_hit, w_slot} = lfcb_decode(w_addr);
  assign {r_hit, r_slot} = lfcb_decode(S_AXI_ARADDR);

  // write fires once both address and data are present and no response pending
  assign S_AXI_AWREADY = CE && !s_q.aw_held && !s_q.bvalid;
  assign S_AXI_WREADY = CE && !s_q.w_held && !s_q.bvalid;
  assign S_AXI_ARREADY = CE && !s_q.rvalid;
  assign do_write = CE && !s_q.bvalid && (s_q.aw_held || S_AXI_AWVALID) && (s_q.w_held || S_AXI_WVALID);

  logic [7:0] cur_byte;
  logic cur_lane;
  assign cur_byte = s_q.w_held ? s_q.wbyte : S_AXI_WDATA[7:0];
  assign cur_lane = s_q.w_held ? s_q.wlane : S_AXI_WSTRB[0];

  always_comb begin
    wr_sel = '0;
    if (do_write && w_hit && cur_lane) begin
      wr_sel[w_slot] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < LFCB_NUM_COEFS; gi++) begin : g_coef
      lfcb_coef_reg #(
        .RST_HIGH(RST_TAB[2*gi]),
        .RST_LOW(RST_TAB[2*gi+1])
      ) u_coef (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .ce(CE),
        .wr_high(wr_sel[2*gi]),
        .wr_low(wr_sel[2*gi+1]),
        .wdata(cur_byte),
        .high_q(reg_val[2*gi]),
        .low_q(reg_val[2*gi+1]),
        .coef(coef[gi])
      );
    end
  endgenerate

  assign EFFECTS_DENOM_FOUR = coef[0];
  assign EFFECTS_DENOM_FIVE = coef[1];
  assign DEEMPH_NUMER_ZERO = coef[2];
  assign DEEMPH_NUMER_ONE = coef[3];
  assign DEEMPH_DENOM_ONE = coef[4];

  always_comb begin
    s_d = s_q;
    if (S_AXI_AWVALID && S_AXI_AWREADY && !do_write) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY && !do_write) begin
      s_d.w_held = 1'b1;
      s_d.wbyte = S_AXI_WDATA[7:0];
      s_d.wlane = S_AXI_WSTRB[0];
    end
    if (do_write) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = w_hit ? LFCB_RESP_OKAY : LFCB_RESP_SLVERR;
    end else if (s_q.bvalid && S_AXI_BREADY) begin
      s_d.bvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = r_hit ? LFCB_RESP_OKAY : LFCB_RESP_SLVERR;
      s_d.rdata = r_hit ? {24'h00_0000, reg_val[r_slot]} : 32'h0000_0000;
    end else if (s_q.rvalid && S_AXI_RREADY) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      s_q <= '0;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign S_AXI_BVALID = s_q.bvalid;
  assign S_AXI_BRESP = s_q.bresp;
  assign S_AXI_RVALID = s_q.rvalid;
  assign S_AXI_RRESP = s_q.rresp;
  assign S_AXI_RDATA = s_q.rdata;

  // checks
  sequence lfcb_reset_seq;
    !RST_N && CE;
  endsequence

  property lfcb_reset_val(logic [15:0] v, logic [15:0] r);
    @(posedge CLK_SYS) lfcb_reset_seq |=> (v == r);
  endproperty

  a_denom_four_reset: assert property (lfcb_reset_val(EFFECTS_DENOM_FOUR, 16'h7D83))
    else $error("denom four reset wrong");
  a_denom_five_reset: assert property (lfcb_reset_val(EFFECTS_DENOM_FIVE, 16'h84EE))
    else $error("denom five reset wrong");
  a_numer_zero_reset: assert property (lfcb_reset_val(DEEMPH_NUMER_ZERO, 16'h3955))
    else $error("numer zero reset wrong");
  a_numer_one_reset: assert property (lfcb_reset_val(DEEMPH_NUMER_ONE, 16'hF32D))
    else $error("numer one reset wrong");
  a_denom_high_reset: assert property (@(posedge CLK_SYS) lfcb_reset_seq |=> DEEMPH_DENOM_ONE[15:8] == 8'h53)
    else $error("denom one high reset wrong");
  a_denom_low_reset: assert property (@(posedge CLK_SYS) lfcb_reset_seq |=> DEEMPH_DENOM_ONE[7:0] == 8'h7E)
    else $error("denom one low reset wrong");
  a_write_lands: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (wr_sel[0] && CE) |=> EFFECTS_DENOM_FOUR[15:8] == $past(cur_byte))
    else $error("high byte write lost");
  a_low_write_lands: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (wr_sel[9] && CE) |=> DEEMPH_DENOM_ONE[7:0] == $past(cur_byte))
    else $error("low byte write lost");
  a_coef_sign_kept: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (wr_sel[2] && CE && cur_byte[7]) |=> EFFECTS_DENOM_FIVE < 0)
    else $error("negative coefficient not signed");
  a_read_answer: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (S_AXI_ARVALID && S_AXI_ARREADY && r_hit) |=> S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h00_0000)
    else $error("read answer wrong");

  // flat view of all five coefficients, for the hold checks
  logic [79:0] coef_flat;
  assign coef_flat = {EFFECTS_DENOM_FOUR, EFFECTS_DENOM_FIVE, DEEMPH_NUMER_ZERO,
    DEEMPH_NUMER_ONE, DEEMPH_DENOM_ONE};

  // write: fires on the edge both channels are in, answer stands from the next
  sequence lfcb_write_taken_seq;
    do_write;
  endsequence

  sequence lfcb_write_answer_seq;
    S_AXI_BVALID && !S_AXI_AWREADY && !S_AXI_WREADY;
  endsequence

  sequence lfcb_write_done_seq;
    S_AXI_BVALID && S_AXI_BREADY && CE;
  endsequence

  // read: address taken, data stands until the master takes it
  sequence lfcb_read_taken_seq;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence

  sequence lfcb_read_answer_seq;
    S_AXI_RVALID && !S_AXI_ARREADY;
  endsequence

  sequence lfcb_read_done_seq;
    S_AXI_RVALID && S_AXI_RREADY && CE;
  endsequence

  a_write_answer: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    lfcb_write_taken_seq |=> lfcb_write_answer_seq)
    else $error("write answer missing");

  a_write_released: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    lfcb_write_done_seq |=> !S_AXI_BVALID)
    else $error("write answer not released");

  a_write_unmapped: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    lfcb_write_taken_seq ##0 !w_hit |=> S_AXI_BRESP == LFCB_RESP_SLVERR && $stable(coef_flat))
    else $error("unmapped write not refused");

  a_strobe_off_keeps: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    lfcb_write_taken_seq ##0 !cur_lane |=> $stable(coef_flat))
    else $error("write without strobe changed a coefficient");

  a_read_next: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    lfcb_read_taken_seq |=> lfcb_read_answer_seq)
    else $error("read answer missing");

  a_read_released: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    lfcb_read_done_seq |=> !S_AXI_RVALID)
    else $error("read answer not released");

  a_read_unmapped: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    lfcb_read_taken_seq ##0 !r_hit |=> S_AXI_RRESP == LFCB_RESP_SLVERR && S_AXI_RDATA == 32'h0000_0000)
    else $error("unmapped read not refused");

  // reset clears both answers; clock enable low freezes everything but reset
  a_reset_idle: assert property (@(posedge CLK_SYS)
    lfcb_reset_seq |=> !S_AXI_BVALID && !S_AXI_RVALID)
    else $error("answer pending after reset");
  a_frozen_state: assert property (@(posedge CLK_SYS)
    !CE |=> $stable(s_q) && $stable(coef_flat))
    else $error("state moved while clock enable low");

  // per coefficient: byte writes land in their half, reads return the byte
  genvar gk;
  generate
    for (gk = 0; gk < LFCB_NUM_COEFS; gk++) begin : g_coef_chk
      a_high_pairs: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        wr_sel[2*gk] |=> coef[gk][15:8] == $past(cur_byte) && coef[gk][7:0] == $past(coef[gk][7:0]))
        else $error("high byte write disturbed its pair");

      a_low_pairs: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        wr_sel[2*gk+1] |=> coef[gk][7:0] == $past(cur_byte) && coef[gk][15:8] == $past(coef[gk][15:8]))
        else $error("low byte write disturbed its pair");

      a_read_high_slot: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        lfcb_read_taken_seq ##0 (r_hit && r_slot == 4'(2*gk)) |=> S_AXI_RDATA[7:0] == $past(reg_val[2*gk]))
        else $error("read returned wrong high byte");

      a_read_low_slot: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        lfcb_read_taken_seq ##0 (r_hit && r_slot == 4'(2*gk+1)) |=> S_AXI_RDATA[7:0] == $past(reg_val[2*gk+1]))
        else $error("read returned wrong low byte");

      a_coef_reset: assert property (@(posedge CLK_SYS)
        lfcb_reset_seq |=> coef[gk] == {RST_TAB[2*gk], RST_TAB[2*gk+1]})
        else $error("coefficient reset value wrong");
    end
  endgenerate
endmodule : lfcb_bank

// ---- verification/lfcb_bank_tb.sv ----
// self-checking bench for the left filter coefficient bank
`timescale 1ns/100ps
module lfcb_bank_tb;
  import lfcb_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic signed [15:0] coef [0:4];
  int fail_count = 0, checks_done = 0;
  logic [7:0] mirror [0:9];
  logic [7:0] rst_val [0:9] = '{LFCB_RST_DENOM_FOUR_HIGH, LFCB_RST_DENOM_FOUR_LOW, LFCB_RST_DENOM_FIVE_HIGH,
    LFCB_RST_DENOM_FIVE_LOW, LFCB_RST_NUMER_ZERO_HIGH, LFCB_RST_NUMER_ZERO_LOW, LFCB_RST_NUMER_ONE_HIGH,
    LFCB_RST_NUMER_ONE_LOW, LFCB_RST_DENOM_ONE_HIGH, LFCB_RST_DENOM_ONE_LOW};
  logic [7:0] new_val [0:9] = '{8'h80, 8'h00, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h01, 8'h5A, 8'hA5};

  lfcb_bank i_lfcb_bank (.CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .EFFECTS_DENOM_FOUR(coef[0]), .EFFECTS_DENOM_FIVE(coef[1]), .DEEMPH_NUMER_ZERO(coef[2]),
    .DEEMPH_NUMER_ONE(coef[3]), .DEEMPH_DENOM_ONE(coef[4]));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic timeout();
    fail_count++;
    $display("MISMATCH handshake expected answer seen none");
    finish_test();
  endtask : timeout

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [7:0] reg_addr(input int k);
    return 8'((int'(LFCB_IDX_FIRST) + k) * 4);
  endfunction : reg_addr

  // expected coefficient port value, sign extended to 32 bits
  function automatic logic [31:0] exp_coef(input int k);
    return {{16{mirror[2*k][7]}}, mirror[2*k], mirror[2*k+1]};
  endfunction : exp_coef

  task automatic axi_write(input logic [7:0] addr, input logic [7:0] data, input logic [3:0] strb,
                           input logic [1:0] exp);
    int n;
    logic aw_left, w_left, aw_hit, w_hit;
    @(posedge clk_sys);
    awaddr <= addr;
    wdata <= {24'h00_0000, data};
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_left = 1'b1;
    w_left = 1'b1;
    n = 0;
    while (aw_left || w_left) begin
      @(negedge clk_sys);
      aw_hit = aw_left & awready;
      w_hit = w_left & wready;
      @(posedge clk_sys);
      if (aw_hit) begin
        awvalid <= 1'b0;
        aw_left = 1'b0;
      end
      if (w_hit) begin
        wvalid <= 1'b0;
        w_left = 1'b0;
      end
      n++;
      if (n > 50) timeout();
    end
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (n > 50) timeout();
    end while (bvalid !== 1'b1);
    chk("write response", {30'd0, exp}, {30'd0, bresp});
    @(posedge clk_sys);
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] addr, input logic [31:0] exp, input logic [1:0] exp_resp);
    int n;
    @(posedge clk_sys);
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (n > 50) timeout();
    end while (arready !== 1'b1);
    @(posedge clk_sys);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (n > 50) timeout();
    end while (rvalid !== 1'b1);
    chk("read data", exp, rdata);
    chk("read response", {30'd0, exp_resp}, {30'd0, rresp});
    @(posedge clk_sys);
    rready <= 1'b0;
  endtask : axi_read

  task automatic do_reset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (mirror[k]) mirror[k] = rst_val[k];
  endtask : do_reset

  task automatic check_all();
    @(negedge clk_sys);
    for (int k = 0; k < 5; k++) chk("coefficient port", exp_coef(k), 32'(coef[k]));
    for (int k = 0; k < 10; k++) axi_read(reg_addr(k), {24'h00_0000, mirror[k]}, LFCB_RESP_OKAY);
  endtask : check_all

  initial begin
    do_reset();
    check_all();
    $display("test reset values done");
    for (int k = 0; k < 10; k++) begin
      axi_write(reg_addr(k), new_val[k], 4'h1, LFCB_RESP_OKAY);
      mirror[k] = new_val[k];
      @(negedge clk_sys);
      chk("byte update", exp_coef(k / 2), 32'(coef[k / 2]));
    end
    check_all();
    chk("most negative", 32'hFFFF_8000, 32'(coef[0]));
    chk("most positive", 32'h0000_7FFF, 32'(coef[1]));
    chk("minus one", 32'hFFFF_FFFF, 32'(coef[2]));
    $display("test write and read back done");
    axi_write(reg_addr(4), 8'h12, 4'h0, LFCB_RESP_OKAY);
    axi_write(8'h40, 8'h12, 4'h1, LFCB_RESP_SLVERR);
    axi_write(8'h45, 8'h12, 4'h1, LFCB_RESP_SLVERR);
    axi_read(8'h6C, 32'h0000_0000, LFCB_RESP_SLVERR);
    axi_write(reg_addr(2), 8'hC0, 4'h1, LFCB_RESP_OKAY);
    mirror[2] = 8'hC0;
    @(negedge clk_sys);
    chk("negative high byte", 32'hFFFF_C0FF, 32'(coef[1]));
    check_all();
    $display("test strobe and unmapped done");
    @(posedge clk_sys);
    ce <= 1'b0;
    @(negedge clk_sys);
    chk("ready while frozen", 32'h0, {29'd0, awready, wready, arready});
    fork
      axi_write(reg_addr(0), 8'h33, 4'h1, LFCB_RESP_OKAY);
      begin
        repeat (4) @(negedge clk_sys);
        chk("response while frozen", 32'h0, {31'd0, bvalid});
        chk("coefficient while frozen", exp_coef(0), 32'(coef[0]));
        @(posedge clk_sys);
        ce <= 1'b1;
      end
    join
    mirror[0] = 8'h33;
    check_all();
    $display("test clock enable done");
    do_reset();
    check_all();
    $display("test second reset done");
    finish_test();
  end
endmodule : lfcb_bank_tb
